// file: src/dcac_regs.vh
// Register map, control fields and reset values of the DMA address counters
`ifndef DCAC_REGS_VH
`define DCAC_REGS_VH

// Channel count and register index within a channel window
`define DCAC_NUM_CH 6
`define DCAC_SRC_IDX 3'h0
`define DCAC_DST_IDX 3'h1
`define DCAC_OFS_IDX 3'h2
`define DCAC_CNT_IDX 3'h3
`define DCAC_CTL_IDX 3'h4

// Global status word, byte address
`define DCAC_STAT_ADDR 8'hc0

// Control bits: enable, end-of-block request enable
`define DCAC_CTL_EN 23
`define DCAC_CTL_EOB_EN 22
// transfer_mode_field bits 21..19
`define DCAC_CTL_SWTRIG 21
`define DCAC_CTL_KEEP 20
`define DCAC_CTL_BLK 19
// Counter split, address modes, dimension and packing
`define DCAC_CTL_DUAL 0
`define DCAC_CTL_SMODE 3:1
`define DCAC_CTL_SDIM 4
`define DCAC_CTL_DMODE 7:5
`define DCAC_CTL_DDIM 8
`define DCAC_CTL_SPACK 9
`define DCAC_CTL_DPACK 10

// addr_mode_field encodings
`define DCAC_AM_NONE 3'h0
`define DCAC_AM_INC1 3'h1
`define DCAC_AM_DEC1 3'h2
`define DCAC_AM_INC3 3'h3
`define DCAC_AM_DEC3 3'h4

// Reset values and packing figures
`define DCAC_REG_RESET 24'h00_0000
`define DCAC_LAST_BYTE 2'h2

`endif

// file: src/dcac_top.v
// DMA channel address counters, transfer engine and byte packing
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "dcac_regs.vh"
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////

module dcac_top (
   input wire core_clk_i, // Core clock, 40 MHz
   input wire rst_n_i, // Async reset, active low
   input wire [7:0] avs_address_i, // Avalon byte address
   input wire avs_read_i, // Avalon read
   input wire avs_write_i, // Avalon write
   input wire [31:0] avs_writedata_i, // Avalon write data
   input wire [3:0] avs_byteenable_i, // Avalon byte lanes
   output reg [31:0] avs_readdata_o, // Avalon read data
   output reg avs_waitrequest_o, // Avalon stall
   input wire [5:0] trig_i, // Per-channel trigger pulses
   output reg bus_req_o, // Access request to the bus unit
   output reg bus_we_o, // Access is a write
   output reg [23:0] bus_addr_o, // Access address
   output reg [23:0] bus_wdata_o, // Write data, byte in [7:0]
   output reg bus_byte_o, // Byte-wide external access
   output reg [2:0] bus_chan_o, // Channel owning the access
   output reg bus_inpage_o, // Access continues a channel run
   input wire bus_ack_i, // Access done
   input wire [23:0] bus_rdata_i, // Read data, byte in [7:0]
   output reg [5:0] eob_req_o // End-of-block pulses
);

////////////////////////////////////////////////////////////////////////
// Engine states
localparam [1:0] ST_IDLE = 2'h0; // Waiting for a ready channel
localparam [1:0] ST_RD = 2'h1; // Source read
localparam [1:0] ST_WR = 2'h2; // Destination write
localparam [1:0] ST_UPD = 2'h3; // Counter and address update

reg [1:0] state; // Engine state
reg [2:0] eng_ch; // Channel being served
reg [1:0] bidx; // Byte index when packing
reg [23:0] data; // Word in flight
wire eng_upd; // One-cycle update strobe
wire busy; // Engine not idle

// Flattened per-channel register views
wire [143:0] src_v; // Source addresses
wire [143:0] dst_v; // Destination addresses
wire [143:0] ofs_v; // Offsets
wire [143:0] cnt_v; // Live counters
wire [143:0] init_v; // Preloaded counts
wire [143:0] ctl_v; // Control words
wire [5:0] pend_v; // Pending triggers
wire [5:0] ready_v; // Channel may run
wire [5:0] eob_set; // End-of-block events

// Bus slave decode
wire [2:0] ch_sel; // Addressed channel
wire [2:0] reg_idx; // Addressed register
wire wr_go; // Write commits this edge
reg [31:0] rd_mux; // Read data source

// Current channel's values
wire [23:0] cur_src; // Source of served channel
wire [23:0] cur_dst; // Destination of served channel
wire [23:0] cur_ofs; // Offset of served channel
wire [23:0] cur_cnt; // Counter of served channel
wire [23:0] cur_init; // Preload of served channel
wire [23:0] cur_ctl; // Control of served channel

// Next values for the served channel
reg row_end; // First-level run ends here
reg blk_last; // Final transfer of the block
reg [23:0] next_cnt; // Counter after transfer
reg [23:0] next_src; // Source after transfer
reg [23:0] next_dst; // Destination after transfer
reg [2:0] pick; // Lowest ready channel
integer k; // Scan index

genvar gi;

////////////////////////////////////////////////////////////////////////
// Byte-lane merge of a bus write into a 24-bit register
function [23:0] merge;
   input [23:0] old;
   input [31:0] wd;
   input [3:0] be;
   begin
      merge[7:0] = be[0] ? wd[7:0] : old[7:0];
      merge[15:8] = be[1] ? wd[15:8] : old[15:8];
      merge[23:16] = be[2] ? wd[23:16] : old[23:16];
   end
endfunction

// Address step for one pointer
function [23:0] step;
   input [23:0] a;
   input [2:0] m;
   input d2;
   input re;
   input [23:0] o;
   begin
      case (m)
         `DCAC_AM_INC1: step = a + 24'h00_0001;
         `DCAC_AM_DEC1: step = a - 24'h00_0001;
         `DCAC_AM_INC3: step = a + 24'h00_0003;
         `DCAC_AM_DEC3: step = a - 24'h00_0003;
         default: step = a;
      endcase
      // Offset replaces the step at the end of a run
      if (m != `DCAC_AM_NONE && d2 && re) begin
         step = a + o;
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////
// Bus slave decode: channel window of 32 bytes each
assign ch_sel = avs_address_i[7:5];
assign reg_idx = avs_address_i[4:2];
assign wr_go = avs_write_i & ~avs_waitrequest_o;

assign busy = (state != ST_IDLE);
assign eng_upd = (state == ST_UPD);

// Served channel's registers
assign cur_src = src_v[eng_ch*24 +: 24];
assign cur_dst = dst_v[eng_ch*24 +: 24];
assign cur_ofs = ofs_v[eng_ch*24 +: 24];
assign cur_cnt = cnt_v[eng_ch*24 +: 24];
assign cur_init = init_v[eng_ch*24 +: 24];
assign cur_ctl = ctl_v[eng_ch*24 +: 24];

////////////////////////////////////////////////////////////////////////
// Per-channel register sets, one identical copy each
generate
   for (gi = 0; gi < `DCAC_NUM_CH; gi = gi + 1) begin : g_ch
      localparam [2:0] CH = gi; // Channel number
      reg [23:0] src; // Source address
      reg [23:0] dst; // Destination address
      reg [23:0] ofs; // addr_offset_reg
      reg [23:0] cnt; // xfer_counter, live
      reg [23:0] init; // xfer_counter preload
      reg [23:0] ctl; // channel_control_reg
      reg pend; // Trigger seen, not served
      wire wsel; // Bus write hits this channel
      wire upd; // Engine updates this channel

      assign wsel = wr_go && (ch_sel == CH);
      assign upd = eng_upd && (eng_ch == CH);

      // Register set; a bus write in the update cycle wins
      always @(posedge core_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            src <= `DCAC_REG_RESET;
            dst <= `DCAC_REG_RESET;
            ofs <= `DCAC_REG_RESET;
            cnt <= `DCAC_REG_RESET;
            init <= `DCAC_REG_RESET;
            ctl <= `DCAC_REG_RESET;
            pend <= 1'b0;
         end else begin
            // Engine write-back after each word
            if (upd) begin
               src <= next_src;
               dst <= next_dst;
               cnt <= next_cnt;
               // Enable dropped unless the mode keeps it
               if (blk_last && !ctl[`DCAC_CTL_KEEP]) begin
                  ctl[`DCAC_CTL_EN] <= 1'b0;
               end
            end
            // Software access; setting enable beats the clear
            if (wsel) begin
               case (reg_idx)
                  `DCAC_SRC_IDX: src <= merge(src, avs_writedata_i, avs_byteenable_i);
                  `DCAC_DST_IDX: dst <= merge(dst, avs_writedata_i, avs_byteenable_i);
                  `DCAC_OFS_IDX: ofs <= merge(ofs, avs_writedata_i, avs_byteenable_i);
                  `DCAC_CNT_IDX: begin
                     // Counter and its preload load together
                     cnt <= merge(init, avs_writedata_i, avs_byteenable_i);
                     init <= merge(init, avs_writedata_i, avs_byteenable_i);
                  end
                  `DCAC_CTL_IDX: ctl <= merge(ctl, avs_writedata_i, avs_byteenable_i);
                  default: begin end // Unused slot: must not undo the enable clear
               endcase
            end
            // Trigger latch; a new trigger beats the clear
            if (trig_i[gi]) begin
               pend <= 1'b1;
            end else if (upd && (!ctl[`DCAC_CTL_BLK] || blk_last)) begin
               pend <= 1'b0;
            end
         end
      end

      // Ready: enabled, and either triggered or in software trigger mode
      assign ready_v[gi] = ctl[`DCAC_CTL_EN] & (pend | ctl[`DCAC_CTL_SWTRIG]);
      // End-of-block event only when enabled
      assign eob_set[gi] = upd & blk_last & ctl[`DCAC_CTL_EOB_EN];
      assign src_v[gi*24 +: 24] = src;
      assign dst_v[gi*24 +: 24] = dst;
      assign ofs_v[gi*24 +: 24] = ofs;
      assign cnt_v[gi*24 +: 24] = cnt;
      assign init_v[gi*24 +: 24] = init;
      assign ctl_v[gi*24 +: 24] = ctl;
      assign pend_v[gi] = pend;
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// Counter decision for the served channel, tested before the transfer
always @* begin
   if (cur_ctl[`DCAC_CTL_DUAL]) begin
      // Dual: upper and lower fields
      row_end = (cur_cnt[11:0] == 12'h000);
      blk_last = row_end && (cur_cnt[23:12] == 12'h000);
      if (blk_last) begin
         next_cnt = cur_init;
      end else if (row_end) begin
         next_cnt = {cur_cnt[23:12] - 12'h001, cur_init[11:0]};
      end else begin
         next_cnt = {cur_cnt[23:12], cur_cnt[11:0] - 12'h001};
      end
   end else begin
      // Single: whole counter, count plus one words
      row_end = 1'b0;
      blk_last = (cur_cnt == 24'h00_0000);
      next_cnt = blk_last ? cur_init : cur_cnt - 24'h00_0001;
   end
   // Each pointer follows its own mode and dimension
   next_src = step(cur_src, cur_ctl[`DCAC_CTL_SMODE], cur_ctl[`DCAC_CTL_SDIM],
                   row_end, cur_ofs);
   next_dst = step(cur_dst, cur_ctl[`DCAC_CTL_DMODE], cur_ctl[`DCAC_CTL_DDIM],
                   row_end, cur_ofs);
end

// Fixed priority: lowest ready channel wins
always @* begin
   pick = 3'h0;
   for (k = `DCAC_NUM_CH - 1; k >= 0; k = k - 1) begin
      if (ready_v[k]) begin
         pick = k[2:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Transfer engine: one word at a time, so channels never overlap
always @(posedge core_clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      state <= ST_IDLE;
      eng_ch <= 3'h0;
      bidx <= 2'h0;
      data <= `DCAC_REG_RESET;
      bus_req_o <= 1'b0;
      bus_we_o <= 1'b0;
      bus_addr_o <= `DCAC_REG_RESET;
      bus_wdata_o <= `DCAC_REG_RESET;
      bus_byte_o <= 1'b0;
      bus_chan_o <= 3'h0;
      bus_inpage_o <= 1'b0;
   end else begin
      case (state)
         ST_IDLE: begin
            // Arbitrate only between words
            if (|ready_v) begin
               eng_ch <= pick;
               state <= ST_RD;
            end
         end
         ST_RD: begin
            if (!bus_req_o) begin
               // Issue source read; byte-wide only if source packing is set
               bus_req_o <= 1'b1;
               bus_we_o <= 1'b0;
               bus_byte_o <= cur_ctl[`DCAC_CTL_SPACK];
               bus_addr_o <= cur_src + {22'h00_0000, bidx};
               bus_chan_o <= eng_ch;
               // Hint survives other traffic between words
               bus_inpage_o <= (cur_cnt != cur_init) | (bidx != 2'h0);
            end else if (bus_ack_i) begin
               bus_req_o <= 1'b0;
               if (bus_byte_o) begin
                  data[bidx*8 +: 8] <= bus_rdata_i[7:0];
               end else begin
                  data <= bus_rdata_i;
               end
               // Third byte or a word completes the read
               if (!bus_byte_o || bidx == `DCAC_LAST_BYTE) begin
                  bidx <= 2'h0;
                  state <= ST_WR;
               end else begin
                  bidx <= bidx + 2'h1;
               end
            end
         end
         ST_WR: begin
            if (!bus_req_o) begin
               // Issue destination write
               bus_req_o <= 1'b1;
               bus_we_o <= 1'b1;
               bus_byte_o <= cur_ctl[`DCAC_CTL_DPACK];
               bus_addr_o <= cur_dst + {22'h00_0000, bidx};
               bus_chan_o <= eng_ch;
               bus_inpage_o <= (cur_cnt != cur_init) | (bidx != 2'h0);
               if (cur_ctl[`DCAC_CTL_DPACK]) begin
                  bus_wdata_o <= {16'h0000, data[bidx*8 +: 8]};
               end else begin
                  bus_wdata_o <= data;
               end
            end else if (bus_ack_i) begin
               bus_req_o <= 1'b0;
               bus_we_o <= 1'b0;
               if (!bus_byte_o || bidx == `DCAC_LAST_BYTE) begin
                  bidx <= 2'h0;
                  state <= ST_UPD;
               end else begin
                  bidx <= bidx + 2'h1;
               end
            end
         end
         ST_UPD: begin
            // Channel registers take next values at this edge
            state <= ST_IDLE;
         end
         default: begin
            state <= ST_IDLE;
         end
      endcase
   end
end

// End-of-block pulses, registered
always @(posedge core_clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      eob_req_o <= 6'h00;
   end else begin
      eob_req_o <= eob_set;
   end
end

////////////////////////////////////////////////////////////////////////
// Read data select; unmapped addresses read zero
always @* begin
   rd_mux = 32'h0000_0000;
   if (avs_address_i == `DCAC_STAT_ADDR) begin
      rd_mux = {18'h0_0000, pend_v, 4'h0, busy, eng_ch};
   end else if (ch_sel < 3'h6) begin
      case (reg_idx)
         `DCAC_SRC_IDX: rd_mux = {8'h00, src_v[ch_sel*24 +: 24]};
         `DCAC_DST_IDX: rd_mux = {8'h00, dst_v[ch_sel*24 +: 24]};
         `DCAC_OFS_IDX: rd_mux = {8'h00, ofs_v[ch_sel*24 +: 24]};
         `DCAC_CNT_IDX: rd_mux = {8'h00, cnt_v[ch_sel*24 +: 24]};
         `DCAC_CTL_IDX: rd_mux = {8'h00, ctl_v[ch_sel*24 +: 24]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
end

// Avalon answer: one low waitrequest cycle per request
always @(posedge core_clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
   end else if (!avs_waitrequest_o) begin
      // Answer cycle ends; master releases now
      avs_waitrequest_o <= 1'b1;
   end else if (avs_read_i || avs_write_i) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= rd_mux;
   end
end

endmodule // dcac_top

// file: bench/dcac_top_chk.sv
// Port checker for the DMA address counters
`timescale 1ns/1ps
module dcac_top_chk (
   input wire core_clk_i, // Core clock
   input wire rst_n_i, // Reset, active low
   input wire avs_read_i, // Register read
   input wire avs_write_i, // Register write
   input wire avs_waitrequest_o, // Register stall
   input wire bus_req_o, // Access request
   input wire bus_we_o, // Access is a write
   input wire [23:0] bus_addr_o, // Access address
   input wire [23:0] bus_wdata_o, // Write data
   input wire bus_byte_o, // Byte access
   input wire [2:0] bus_chan_o, // Owning channel
   input wire bus_inpage_o, // Run continuation hint
   input wire bus_ack_i, // Access done
   input wire [5:0] eob_req_o // End-of-block pulses
);
   reg [1:0] bidx; // Byte slot in a packed word
   reg [23:0] last_addr; // Last byte address
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   // Byte slot tracker, so order inside a word is visible
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bidx <= 2'h0;
         last_addr <= 24'h00_0000;
      end else if (bus_req_o && bus_ack_i && bus_byte_o) begin
         bidx <= (bidx == 2'h2) ? 2'h0 : bidx + 2'h1;
         last_addr <= bus_addr_o;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   wait_ans_a:
      assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("register request not answered");
   wait_one_a:
      assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("register answer longer than one cycle");
   req_hold_a:
      assert property (bus_req_o && !bus_ack_i |=> bus_req_o && $stable(bus_addr_o)
         && $stable(bus_we_o) && $stable(bus_wdata_o) && $stable(bus_chan_o))
      else $error("access changed before acknowledge");
   req_drop_a:
      assert property (bus_req_o && bus_ack_i |=> !bus_req_o)
      else $error("access not released after acknowledge");
   rd_then_wr_a:
      assert property (bus_req_o && bus_ack_i && !bus_we_o && (!bus_byte_o || bidx == 2'h2)
         |=> !bus_req_o ##[1:2] (bus_req_o && bus_we_o))
      else $error("word read not followed by its write");
   pack_seq_a:
      assert property (bus_req_o && bus_byte_o && bidx != 2'h0 |-> bus_addr_o == last_addr + 24'h1)
      else $error("packed bytes not consecutive");
   inpage_byte_a:
      assert property (bus_req_o && bus_byte_o && bidx != 2'h0 |-> bus_inpage_o)
      else $error("later byte of a word not marked as run continuation");
   byte_data_a:
      assert property (bus_req_o && bus_byte_o && bus_we_o |-> bus_wdata_o[23:8] == 16'h0000)
      else $error("byte write carries upper data");
   eob_pulse_a:
      assert property ((|eob_req_o) |=> eob_req_o == 6'h00)
      else $error("end-of-block request longer than a pulse");
   eob_after_a:
      assert property ((|eob_req_o) |-> $past(bus_ack_i, 1) || $past(bus_ack_i, 2)
         || $past(bus_ack_i, 3))
      else $error("end-of-block request without a finished transfer");
   // Main scenarios reached
   cover property (|eob_req_o);
   cover property (bus_req_o && bus_ack_i && bus_byte_o && !bus_we_o);
   cover property (bus_req_o && bus_ack_i && bus_byte_o && bus_we_o);
endmodule // dcac_top_chk

bind dcac_top dcac_top_chk chk (
   .core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_waitrequest_o(avs_waitrequest_o),
   .bus_req_o(bus_req_o),
   .bus_we_o(bus_we_o),
   .bus_addr_o(bus_addr_o),
   .bus_wdata_o(bus_wdata_o),
   .bus_byte_o(bus_byte_o),
   .bus_chan_o(bus_chan_o),
   .bus_inpage_o(bus_inpage_o),
   .bus_ack_i(bus_ack_i),
   .eob_req_o(eob_req_o)
);

// file: bench/dcac_bus_model.sv
// Bus unit and memory model on the far side of the engine
`timescale 1ns/1ps
module dcac_bus_model (
   input wire clk_i, // Core clock
   input wire rst_n_i, // Reset, active low
   input wire req_i, // Access request
   input wire we_i, // Access is a write
   input wire [23:0] addr_i, // Access address
   input wire [23:0] wdata_i, // Write data
   input wire byte_i, // Byte access
   input wire [3:0] lat_i, // Extra wait cycles
   output reg ack_o, // Access done
   output reg [23:0] rdata_o // Read data
);
   reg [23:0] mem [0:255]; // Word store, bytes in low lane
   reg [3:0] cnt; // Wait counter
   ////////////////////////////////////////////////////////////////////////
   // One access at a time; data is garbage outside the ack cycle
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         cnt <= 4'h0;
         rdata_o <= 24'h00_0000;
      end else if (req_i && !ack_o && cnt >= lat_i) begin
         ack_o <= 1'b1;
         cnt <= 4'h0;
         if (we_i && byte_i) begin
            mem[addr_i[7:0]][7:0] <= wdata_i[7:0];
         end else if (we_i) begin
            mem[addr_i[7:0]] <= wdata_i;
         end else if (byte_i) begin
            rdata_o <= {~rdata_o[23:8], mem[addr_i[7:0]][7:0]};
         end else begin
            rdata_o <= mem[addr_i[7:0]];
         end
      end else begin
         // Slow answer: count wait states, scramble released data
         ack_o <= 1'b0;
         cnt <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
         rdata_o <= ~rdata_o;
      end
   end
endmodule // dcac_bus_model

// file: bench/dcac_top_tb.sv
// Self-checking bench for the DMA address counters
`timescale 1ns/1ps
module dcac_top_tb;
   reg core_clk_i, rst_n_i, avs_read_i, avs_write_i; // Clock, reset, strobes
   reg [7:0] avs_address_i; // Register address
   reg [31:0] avs_writedata_i; // Register write data
   reg [5:0] trig_i; // Channel triggers
   reg [3:0] lat; // Partner wait cycles
   wire [31:0] avs_readdata_o; // Register read data
   wire avs_waitrequest_o, bus_req_o, bus_we_o, bus_byte_o, bus_ack_i; // Handshakes
   wire [23:0] bus_addr_o, bus_wdata_o, bus_rdata_i; // Access path
   wire [5:0] eob_req_o; // End-of-block pulses
   int num_errors, checked, i, ch, r, k; // Counters and loop indices
   int eobs [0:5]; // End-of-block pulses seen
   reg [31:0] q; // Last read value
   reg [23:0] e, w; // Expectation scratch
   reg [7:0] b; // Byte address scratch
   ////////////////////////////////////////////////////////////////////////
   dcac_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .trig_i(trig_i), .bus_req_o(bus_req_o),
      .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
      .bus_byte_o(bus_byte_o), .bus_chan_o(), .bus_inpage_o(), .bus_ack_i(bus_ack_i),
      .bus_rdata_i(bus_rdata_i), .eob_req_o(eob_req_o));
   dcac_bus_model partner (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(bus_req_o),
      .we_i(bus_we_o), .addr_i(bus_addr_o), .wdata_i(bus_wdata_o), .byte_i(bus_byte_o),
      .lat_i(lat), .ack_o(bus_ack_i), .rdata_o(bus_rdata_i));
   ////////////////////////////////////////////////////////////////////////
   // 40 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   // Count end-of-block pulses per channel
   always @(posedge core_clk_i) begin
      for (k = 0; k < 6; k++) if (eob_req_o[k] === 1'b1) eobs[k]++;
   end
   // Fill pattern, distinct in each byte lane
   function automatic [23:0] pat(input [7:0] a);
      pat = {a ^ 8'h3c, a, ~a};
   endfunction
   function automatic [7:0] ra(input [2:0] c, input [2:0] x);
      ra = {c, x, 2'b00};
   endfunction
   // One register access; holds everything until waitrequest low
   task automatic acc(input bit wr, input [7:0] a, input [31:0] d, output [31:0] v);
      int n;
      begin
         n = 0;
         avs_address_i <= a;
         avs_writedata_i <= d;
         avs_write_i <= wr;
         avs_read_i <= !wr;
         do begin
            @(posedge core_clk_i);
            n++;
         end while (avs_waitrequest_o !== 1'b0 && n < 100);
         if (n >= 100) num_errors++;
         v = avs_readdata_o;
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
         @(posedge core_clk_i);
      end
   endtask
   task automatic chk(input [31:0] got, input [31:0] exp);
      begin
         checked++;
         if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task automatic rd_chk(input [2:0] c, input [2:0] x, input [31:0] exp);
      begin
         acc(1'b0, ra(c, x), 32'h0000_0000, q);
         chk(q, exp);
      end
   endtask
   // Counter goes in before control, so the run starts fully set up
   task automatic setup(input [2:0] c, input [23:0] s, d, o, n, ctl);
      begin
         acc(1'b1, ra(c, 3'h0), {8'h00, s}, q);
         acc(1'b1, ra(c, 3'h1), {8'h00, d}, q);
         acc(1'b1, ra(c, 3'h2), {8'h00, o}, q);
         acc(1'b1, ra(c, 3'h3), {8'h00, n}, q);
         acc(1'b1, ra(c, 3'h4), {8'h00, ctl}, q);
      end
   endtask
   // Poll until the enable bit drops, then let the pulse land
   task automatic wait_clr(input [2:0] c);
      int n;
      begin
         n = 0;
         q = 32'h0080_0000;
         while (q[23] !== 1'b0 && n < 300) begin
            acc(1'b0, ra(c, 3'h4), 32'h0000_0000, q);
            n++;
         end
         if (n >= 300) num_errors++;
         repeat (4) @(posedge core_clk_i);
      end
   endtask
   task wrap_up;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   // Watchdog well past the expected run
   initial begin
      repeat (30000) @(posedge core_clk_i);
      num_errors++;
      wrap_up;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, trig_i} = 0;
      lat = 4'h0;
      num_errors = 0;
      checked = 0;
      for (i = 0; i < 6; i++) eobs[i] = 0;
      for (i = 0; i < 256; i++) partner.mem[i] = pat(8'(i));
      repeat (6) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      // Reset state, then the same register set in every channel
      for (ch = 0; ch < 6; ch++) begin
         rd_chk(ch[2:0], 3'h4, 32'h0);
         for (r = 0; r < 4; r++) begin
            acc(1'b1, ra(ch[2:0], r[2:0]), {8'hff, ch[7:0], r[7:0], 8'h5a}, q);
            rd_chk(ch[2:0], r[2:0], {8'h00, ch[7:0], r[7:0], 8'h5a});
         end
      end
      acc(1'b0, 8'he0, 32'h0, q);
      chk(q, 32'h0);
      // Single counter, source up by one, destination down by one
      setup(3'h0, 24'h10, 24'h4f, 24'h0, 24'h2, 24'he8_0042);
      wait_clr(3'h0);
      for (i = 0; i < 3; i++) chk(partner.mem[79 - i], pat(8'(16 + i)));
      rd_chk(3'h0, 3'h0, 32'h13);
      rd_chk(3'h0, 3'h1, 32'h4c);
      rd_chk(3'h0, 3'h3, 32'h2);
      chk(eobs[0], 1);
      // Dual counter circular buffer of three words, slow partner
      lat <= 4'h3;
      setup(3'h1, 24'h20, 24'h60, 24'hff_fffe, 24'h00_1002, 24'ha8_0033);
      wait_clr(3'h1);
      for (i = 0; i < 6; i++) chk(partner.mem[96 + i], pat(8'(32 + i % 3)));
      rd_chk(3'h1, 3'h0, 32'h20);
      rd_chk(3'h1, 3'h1, 32'h66);
      rd_chk(3'h1, 3'h3, 32'h1002);
      chk(eobs[1], 0);
      // Packed byte reads, hardware trigger, enable kept
      lat <= 4'h1;
      setup(3'h2, 24'h90, 24'hd0, 24'h0, 24'h1, 24'hd8_0226);
      trig_i <= 6'h04;
      @(posedge core_clk_i);
      trig_i <= 6'h00;
      for (i = 0; i < 2000 && eobs[2] == 0; i++) @(posedge core_clk_i);
      for (i = 0; i < 2; i++) begin
         b = 8'(144 + 3 * i);
         chk(partner.mem[208 + i], {~(b + 8'h2), ~(b + 8'h1), ~b});
      end
      rd_chk(3'h2, 3'h0, 32'h96);
      acc(1'b0, ra(3'h2, 3'h4), 32'h0, q);
      chk(q[23], 1);
      chk(eobs[2], 1);
      // Packed byte writes, source fixed, destination down by three
      lat <= 4'h0;
      setup(3'h3, 24'h30, 24'hb3, 24'h0, 24'h1, 24'ha8_0480);
      wait_clr(3'h3);
      for (i = 0; i < 6; i++) begin
         e = pat(8'(176 + i));
         w = pat(8'h30) >> (8 * (i % 3));
         chk(partner.mem[176 + i], {e[23:8], w[7:0]});
      end
      rd_chk(3'h3, 3'h0, 32'h30);
      rd_chk(3'h3, 3'h1, 32'had);
      wrap_up;
   end
endmodule // dcac_top_tb
